// >>> src/ebc_regs.svh
`ifndef EBC_REGS_SVH
`define EBC_REGS_SVH
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - An 8-bit space uses the upper data lane, bits 15 to 8, except burst fetches, which read full 16-bit words.
// - 2-state spaces never get wait states; 3-state spaces may.
// - Normal mode, 16-bit byte access: even uses upper lane, odd lower.
// - Multiplexed mode, 16-bit byte access: even uses upper lane, odd lower.
// - Normal program wait inserts the configured count between second and third states.
// - Normal pin wait: configured waits, then more while the wait input is low.
// - Normal auto-wait: configured count only if wait input low; never more.
// - Reset gives 3-state access, three program waits, wait input disabled.
// - Multiplexed program wait: 0 or 1 address wait, 0 to 3 data waits.
// - Multiplexed pin wait: configured data waits, then more while wait input low.
// - Multiplexed auto-wait: configured data waits only if wait input low; capped.
// - Burst ROM bursts happen only on instruction fetches, never data accesses.
// - Burst initial cycle follows the access-state bit; waits only when it is 1.
// - Each later burst cycle lasts 1 or 2 states, never with wait states.
// - A burst holds at most four words, or eight when the limit bit is 1.
// - The burst initial cycle supports the ordinary program and pin waits.
// - Reads strobe both lanes; writes use high strobe upper, low strobe lower.
// - In an 8-bit space words take two byte cycles, longwords four; burst fetch words take one 16-bit cycle.
//////////////////////////////////////////////////////////////////////////////
`define EBC_OFF_WAIT 8'h00
`define EBC_OFF_AREA 8'h04
`define EBC_OFF_BUS 8'h08
`define EBC_OFF_STAT 8'h0c
`define EBC_WC_LSB 0
`define EBC_AST_BIT 2
`define EBC_MODE_LSB 3
`define EBC_WCBIG_LSB 0
`define EBC_WCCOP_LSB 2
`define EBC_AWBIG_BIT 4
`define EBC_AWCOP_BIT 5
`define EBC_AWIOS_BIT 6
`define EBC_BROM_BIT 0
`define EBC_BLEN_BIT 1
`define EBC_BWORD_BIT 2
`define EBC_MUX_BIT 3
`define EBC_BUS8_BIT 4
`define EBC_RST_WC 2'h3
`define EBC_RST_AST 1'b1
`define EBC_BURST_SHORT 4'h4
`define EBC_BURST_LONG 4'h8
`endif

// >>> src/ebc_pkg.sv
package ebc_pkg;
    typedef enum {S_IDLE, S_T1, S_TAW, S_T2M, S_T3M, S_WP, S_TW, S_END, S_BURST} ebc_state_e;
    typedef enum logic [1:0] {WM_PROG, WM_PIN, WM_AUTO} ebc_wmode_e;
    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} ebc_size_e;
    typedef enum logic [1:0] {AREA_BASIC, AREA_BIG, AREA_COP, AREA_IOS} ebc_area_e;
endpackage

// >>> src/ebc_lane.sv
`timescale 1ns/10ps
module ebc_lane
    import ebc_pkg::*;
(
    // Access shape
    input wire logic bus8,
    input wire logic byte_unit,
    input wire logic odd,
    input wire logic write,
    input wire logic strobe,
    // Data
    input wire logic [15:0] wdata,
    input wire logic [15:0] din,
    output logic [15:0] dout,
    output logic [1:0] oe_n,
    output logic [15:0] rd_unit,
    // Strobes
    output logic rd_n,
    output logic hwr_n,
    output logic lwr_n
);
    logic use_hi;
    logic use_lo;
    logic wr_on;

    assign use_hi = bus8 || !byte_unit || !odd;
    assign use_lo = !bus8 && (!byte_unit || odd);
    assign wr_on = strobe && write;
    assign dout = wdata;
    assign oe_n = {!(wr_on && use_hi), !(wr_on && use_lo)};
    assign rd_n = !(strobe && !write);
    assign hwr_n = !(wr_on && use_hi);
    assign lwr_n = !(wr_on && use_lo);
    assign rd_unit = !byte_unit ? din : {8'h00, (use_lo ? din[7:0] : din[15:8])};
endmodule

// >>> src/ebc_ctrl.sv
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "ebc_regs.svh"
module ebc_ctrl
    import ebc_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Access request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_fetch,
    input wire logic [1:0] req_size,
    input wire logic [1:0] req_area,
    input wire logic [23:0] req_addr,
    input wire logic [31:0] req_wdata,
    input wire logic [3:0] req_words,
    // Answer
    output logic rsp_valid,
    output logic rsp_last,
    output logic [31:0] rsp_rdata,
    // External bus
    output logic [23:0] ext_addr,
    output logic [15:0] ext_data_out,
    output logic [1:0] ext_data_oe_n,
    input wire logic [15:0] ext_data_in,
    output logic as_n,
    output logic rd_n,
    output logic high_write_strobe_n,
    output logic low_write_strobe_n,
    input wire logic wait_n
);
    function automatic logic [1:0] pick_wc(input logic [1:0] area, input logic [1:0] mode,
                                           input logic [1:0] gen, input logic [1:0] big,
                                           input logic [1:0] cop);
        if (area == AREA_COP) begin
            return cop;
        end
        if (area == AREA_BIG && mode != WM_PIN && mode != WM_AUTO) begin
            return big;
        end
        return gen;
    endfunction

    function automatic logic [23:0] step(input logic [23:0] addr, input logic one);
        return addr + (one ? 24'h000001 : 24'h000002);
    endfunction

    //////////////////////////////////////////////////////////////////////////
    logic [1:0] wc_gen;
    logic [1:0] wc_big;
    logic [1:0] wc_cop;
    logic [1:0] wmode;
    logic ast;
    logic aw_big;
    logic aw_cop;
    logic aw_ios;
    logic brom_en;
    logic blen_sel;
    logic bword_sel;
    logic mux_mode;
    logic bus8;
    logic wr;
    logic mapped;

    ebc_state_e state;
    ebc_state_e next_state;
    ebc_state_e after_unit;
    logic cur_write;
    logic cur_fetch;
    logic cur_ast;
    logic cur_aw;
    logic cur_mux;
    logic cur_bus8;
    logic cur_blen;
    logic [1:0] cur_size;
    logic [1:0] cur_mode;
    logic [1:0] cur_wc;
    logic [1:0] wcnt;
    logic [23:0] cur_addr;
    logic [31:0] wbuf;
    logic [31:0] acc;
    logic [31:0] next_acc;
    logic [2:0] units_left;
    logic [3:0] words_left;
    logic [3:0] req_w;
    logic [3:0] w_lim;
    logic bsub;
    logic bsub_done;
    logic take;
    logic burst_req;
    logic byte_unit;
    logic prog_like;
    logic pin_hold;
    logic wp_wait;
    logic unit_end;
    logic addr_ph;
    logic data_ph;
    logic [15:0] lane_dout;
    logic [1:0] lane_oe_n;
    logic [15:0] rd_unit;

    //////////////////////////////////////////////////////////////////////////
    assign wr = psel && penable && pwrite;
    assign mapped = paddr == `EBC_OFF_WAIT || paddr == `EBC_OFF_AREA ||
                    paddr == `EBC_OFF_BUS || paddr == `EBC_OFF_STAT;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Changes take effect at the next access; a running one keeps its snapshot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wc_gen <= `EBC_RST_WC;
            ast <= `EBC_RST_AST;
            wmode <= WM_PROG;
            wc_big <= `EBC_RST_WC;
            wc_cop <= `EBC_RST_WC;
            aw_big <= 1'b0;
            aw_cop <= 1'b0;
            aw_ios <= 1'b0;
            brom_en <= 1'b0;
            blen_sel <= 1'b0;
            bword_sel <= 1'b0;
            mux_mode <= 1'b0;
            bus8 <= 1'b0;
        end else if (wr) begin
            case (paddr)
                `EBC_OFF_WAIT: begin
                    wc_gen <= pwdata[`EBC_WC_LSB +: 2];
                    ast <= pwdata[`EBC_AST_BIT];
                    wmode <= pwdata[`EBC_MODE_LSB +: 2];
                end
                `EBC_OFF_AREA: begin
                    wc_big <= pwdata[`EBC_WCBIG_LSB +: 2];
                    wc_cop <= pwdata[`EBC_WCCOP_LSB +: 2];
                    aw_big <= pwdata[`EBC_AWBIG_BIT];
                    aw_cop <= pwdata[`EBC_AWCOP_BIT];
                    aw_ios <= pwdata[`EBC_AWIOS_BIT];
                end
                `EBC_OFF_BUS: begin
                    brom_en <= pwdata[`EBC_BROM_BIT];
                    blen_sel <= pwdata[`EBC_BLEN_BIT];
                    bword_sel <= pwdata[`EBC_BWORD_BIT];
                    mux_mode <= pwdata[`EBC_MUX_BIT];
                    bus8 <= pwdata[`EBC_BUS8_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data is latched in the setup phase so it is stable for the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            case (paddr)
                `EBC_OFF_WAIT: prdata <= {27'h0, wmode, ast, wc_gen};
                `EBC_OFF_AREA: prdata <= {25'h0, aw_ios, aw_cop, aw_big, wc_cop, wc_big};
                `EBC_OFF_BUS: prdata <= {27'h0, bus8, mux_mode, bword_sel, blen_sel, brom_en};
                `EBC_OFF_STAT: prdata <= {24'h0, words_left, units_left, state != S_IDLE};
                default: prdata <= 32'h0;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    assign req_ready = state == S_IDLE;
    assign take = req_valid && req_ready;
    assign burst_req = brom_en && req_fetch && !req_write;
    assign byte_unit = !cur_fetch && (cur_bus8 || cur_size == SZ_BYTE);
    assign prog_like = cur_mode != WM_PIN && cur_mode != WM_AUTO;
    assign pin_hold = cur_mode == WM_PIN && !wait_n;
    assign wp_wait = cur_ast && ((prog_like && cur_wc != 2'h0) ||
                     (cur_mode == WM_PIN && (cur_wc != 2'h0 || !wait_n)) ||
                     (cur_mode == WM_AUTO && !wait_n && cur_wc != 2'h0));
    assign bsub_done = !cur_blen || bsub;
    assign unit_end = (state == S_WP && !cur_ast) || state == S_END || (state == S_BURST && bsub_done);
    assign req_w = (req_words == 4'h0) ? 4'h1 : req_words;
    assign w_lim = bword_sel ? `EBC_BURST_LONG : `EBC_BURST_SHORT;

    always_comb begin
        if (cur_fetch && words_left > 4'h1) begin
            after_unit = S_BURST;
        end else if (units_left > 3'h1) begin
            after_unit = S_T1;
        end else begin
            after_unit = S_IDLE;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: if (req_valid) next_state = S_T1;
            S_T1: begin
                if (!cur_mux) next_state = S_WP;
                else if (cur_aw) next_state = S_TAW;
                else next_state = S_T2M;
            end
            S_TAW: next_state = S_T2M;
            S_T2M: next_state = S_T3M;
            S_T3M: next_state = S_WP;
            S_WP: begin
                if (wp_wait) next_state = S_TW;
                else if (cur_ast) next_state = S_END;
                else next_state = after_unit;
            end
            S_TW: if (wcnt == 2'h0 && !pin_hold) next_state = S_END;
            S_END: next_state = after_unit;
            S_BURST: if (bsub_done) next_state = after_unit;
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Snapshot of request and configuration, then unit stepping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_write <= 1'b0;
            cur_fetch <= 1'b0;
            cur_size <= SZ_BYTE;
            cur_addr <= 24'h0;
            wbuf <= 32'h0;
            cur_ast <= 1'b0;
            cur_mode <= WM_PROG;
            cur_wc <= 2'h0;
            cur_aw <= 1'b0;
            cur_mux <= 1'b0;
            cur_bus8 <= 1'b0;
            cur_blen <= 1'b0;
        end else if (take) begin
            cur_write <= req_write;
            cur_fetch <= burst_req;
            cur_size <= burst_req ? SZ_WORD : req_size;
            cur_addr <= req_addr;
            wbuf <= (req_size == SZ_BYTE) ? {req_wdata[7:0], 24'h0} :
                    (req_size == SZ_WORD) ? {req_wdata[15:0], 16'h0} : req_wdata;
            cur_ast <= ast;
            cur_mode <= wmode;
            cur_wc <= pick_wc(req_area, wmode, wc_gen, wc_big, wc_cop);
            cur_aw <= (req_area == AREA_BIG && aw_big) || (req_area == AREA_COP && aw_cop) ||
                      (req_area == AREA_IOS && aw_ios);
            cur_mux <= mux_mode;
            cur_bus8 <= bus8 && !burst_req;
            cur_blen <= blen_sel;
        end else if (unit_end) begin
            cur_addr <= step(cur_addr, byte_unit);
            wbuf <= byte_unit ? {wbuf[23:0], 8'h0} : {wbuf[15:0], 16'h0};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            units_left <= 3'h0;
            words_left <= 4'h0;
        end else if (take) begin
            if (burst_req) begin
                units_left <= 3'h1;
                words_left <= (req_w > w_lim) ? w_lim : req_w;
            end else begin
                units_left <= !bus8 ? ((req_size == SZ_LONG) ? 3'h2 : 3'h1) :
                              (req_size == SZ_LONG) ? 3'h4 : (req_size == SZ_WORD) ? 3'h2 : 3'h1;
                words_left <= 4'h0;
            end
        end else if (unit_end) begin
            if (units_left != 3'h0) units_left <= units_left - 3'h1;
            if (words_left != 4'h0) words_left <= words_left - 4'h1;
        end
    end

    // Burst cycles reset the sub-state count, so no wait state can slip in
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wcnt <= 2'h0;
            bsub <= 1'b0;
        end else begin
            if (state == S_WP && next_state == S_TW) begin
                wcnt <= (cur_wc == 2'h0) ? 2'h0 : cur_wc - 2'h1;
            end else if (state == S_TW && wcnt != 2'h0) begin
                wcnt <= wcnt - 2'h1;
            end
            bsub <= (state == S_BURST) ? (cur_blen && !bsub) : 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    assign next_acc = byte_unit ? {acc[23:0], rd_unit[7:0]} : {acc[15:0], rd_unit};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= 32'h0;
            rsp_valid <= 1'b0;
            rsp_last <= 1'b0;
            rsp_rdata <= 32'h0;
        end else begin
            rsp_valid <= 1'b0;
            rsp_last <= 1'b0;
            if (take) begin
                acc <= 32'h0;
            end else if (unit_end) begin
                acc <= next_acc;
                if (cur_fetch) begin
                    rsp_valid <= 1'b1;
                    rsp_last <= next_state == S_IDLE;
                    rsp_rdata <= {16'h0, rd_unit};
                end else if (next_state == S_IDLE) begin
                    rsp_valid <= 1'b1;
                    rsp_last <= 1'b1;
                    rsp_rdata <= cur_write ? 32'h0 : next_acc;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Pins decode straight from state flops; no extra pipeline stage
    assign addr_ph = cur_mux && (state == S_T1 || state == S_TAW || state == S_T2M);
    assign data_ph = state == S_T3M || state == S_WP || state == S_TW || state == S_END || state == S_BURST;
    assign ext_addr = cur_addr;
    assign as_n = !(state != S_IDLE && state != S_BURST && (!cur_mux || addr_ph));
    assign ext_data_out = addr_ph ? cur_addr[15:0] : lane_dout;
    assign ext_data_oe_n = addr_ph ? 2'b00 : lane_oe_n;

    ebc_lane i_ebc_lane (
        .bus8(cur_bus8),
        .byte_unit(byte_unit),
        .odd(cur_addr[0]),
        .write(cur_write),
        .strobe(data_ph),
        .wdata(byte_unit ? {wbuf[31:24], wbuf[31:24]} : wbuf[31:16]),
        .din(ext_data_in),
        .dout(lane_dout),
        .oe_n(lane_oe_n),
        .rd_unit(rd_unit),
        .rd_n(rd_n),
        .hwr_n(high_write_strobe_n),
        .lwr_n(low_write_strobe_n)
    );

    //////////////////////////////////////////////////////////////////////////
    property p_upper_only;
        @(posedge pclk) disable iff (!presetn)
        (cur_bus8 && data_ph && cur_write) |-> (low_write_strobe_n && ext_data_oe_n[0]);
    endproperty
    a_upper_only: assert property (p_upper_only)
        else $error("8-bit space used lower lane");
    property p_no_wait_2st;
        @(posedge pclk) disable iff (!presetn)
        (state == S_TW) |-> cur_ast;
    endproperty
    a_no_wait_2st: assert property (p_no_wait_2st)
        else $error("wait state in 2-state space");
    property p_odd_low;
        @(posedge pclk) disable iff (!presetn)
        (!cur_mux && data_ph && cur_write && byte_unit && !cur_bus8 && cur_addr[0])
        |-> (!low_write_strobe_n && high_write_strobe_n);
    endproperty
    a_odd_low: assert property (p_odd_low)
        else $error("odd byte not on lower lane");
    property p_mux_even_hi;
        @(posedge pclk) disable iff (!presetn)
        (cur_mux && data_ph && cur_write && byte_unit && !cur_bus8 && !cur_addr[0])
        |-> (!high_write_strobe_n && low_write_strobe_n);
    endproperty
    a_mux_even_hi: assert property (p_mux_even_hi)
        else $error("even byte not on upper lane");
    property p_prog_three;
        @(posedge pclk) disable iff (!presetn)
        (state == S_WP && cur_ast && prog_like && cur_wc == 2'h3) |=> (state == S_TW)[*3] ##1 (state == S_END);
    endproperty
    a_prog_three: assert property (p_prog_three)
        else $error("program wait count wrong");
    property p_pin_hold;
        @(posedge pclk) disable iff (!presetn)
        (state == S_TW && wcnt == 2'h0 && cur_mode == WM_PIN && !wait_n) |=> (state == S_TW);
    endproperty
    a_pin_hold: assert property (p_pin_hold)
        else $error("pin wait ended while input low");
    property p_auto_skip;
        @(posedge pclk) disable iff (!presetn)
        (state == S_WP && cur_ast && cur_mode == WM_AUTO && wait_n) |=> (state == S_END);
    endproperty
    a_auto_skip: assert property (p_auto_skip)
        else $error("auto-wait inserted with input high");
    property p_auto_cap;
        @(posedge pclk) disable iff (!presetn)
        (state == S_WP && cur_ast && cur_mode == WM_AUTO && !wait_n && cur_wc == 2'h2)
        |=> (state == S_TW)[*2] ##1 (state == S_END);
    endproperty
    a_auto_cap: assert property (p_auto_cap)
        else $error("auto-wait count not capped");
    property p_no_aw;
        @(posedge pclk) disable iff (!presetn)
        (state == S_T1 && cur_mux && !cur_aw) |=> (state == S_T2M);
    endproperty
    a_no_aw: assert property (p_no_aw)
        else $error("address wait not configured");
    property p_burst_fetch;
        @(posedge pclk) disable iff (!presetn)
        (state == S_BURST) |-> (cur_fetch && !cur_write);
    endproperty
    a_burst_fetch: assert property (p_burst_fetch)
        else $error("burst on non-fetch access");
    property p_burst_nowait;
        @(posedge pclk) disable iff (!presetn)
        (state == S_BURST) |=> (state != S_TW);
    endproperty
    a_burst_nowait: assert property (p_burst_nowait)
        else $error("wait in burst cycle");
    property p_burst_four;
        @(posedge pclk) disable iff (!presetn)
        (take && burst_req && !bword_sel) |=> (words_left <= `EBC_BURST_SHORT);
    endproperty
    a_burst_four: assert property (p_burst_four)
        else $error("burst longer than four words");
    property p_read_strobe;
        @(posedge pclk) disable iff (!presetn)
        (data_ph && !cur_write) |-> (!rd_n && high_write_strobe_n && low_write_strobe_n);
    endproperty
    a_read_strobe: assert property (p_read_strobe)
        else $error("read strobe wrong");
    property p_prog_ignore;
        @(posedge pclk) disable iff (!presetn)
        (state == S_TW && prog_like && wcnt == 2'h0) |=> (state != S_TW);
    endproperty
    a_prog_ignore: assert property (p_prog_ignore)
        else $error("program wait extended by pin");
endmodule

// >>> test/ebc_mem_model.sv
`timescale 1ns/10ps
module ebc_mem_model (
    // Bus side
    input wire logic pclk,
    input wire logic [23:0] ext_addr,
    input wire logic [15:0] ext_data_out,
    input wire logic rd_n,
    input wire logic high_write_strobe_n,
    input wire logic low_write_strobe_n,
    // Slow device setting
    input wire logic [3:0] wait_hold,
    // Device outputs
    output logic [15:0] ext_data_in,
    output logic wait_n
);
    logic [15:0] mem [0:255];
    logic [15:0] last = 16'h0000;
    logic [3:0] cnt = 4'h0;
    logic busy;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = {i[7:0] ^ 8'ha5, i[7:0]};
        end
    end
    assign busy = !(rd_n && high_write_strobe_n && low_write_strobe_n);
    // Slow device holds wait low for the first strobe cycles of each unit
    assign wait_n = !(busy && cnt < wait_hold);
    // Released bus shows the inverse, so a stale sample cannot pass
    assign ext_data_in = !rd_n ? mem[ext_addr[8:1]] : ~last;
    always @(posedge pclk) begin
        cnt <= busy ? cnt + 4'h1 : 4'h0;
        if (!rd_n) last <= mem[ext_addr[8:1]];
        if (!high_write_strobe_n) mem[ext_addr[8:1]][15:8] <= ext_data_out[15:8];
        if (!low_write_strobe_n) mem[ext_addr[8:1]][7:0] <= ext_data_out[7:0];
    end
endmodule

// >>> test/ebc_ctrl_tb.sv
`timescale 1ns/10ps
module ebc_ctrl_tb;
    import ebc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, req_wdata = 32'h0, rsp_rdata, q;
    logic req_valid = 0, req_ready, req_write = 0, req_fetch = 0, rsp_valid, rsp_last;
    logic [1:0] req_size = 2'h0, req_area = 2'h0, ext_data_oe_n, oe_seen;
    logic [23:0] req_addr = 24'h0, ext_addr;
    logic [3:0] req_words = 4'h0, wait_hold = 4'h0;
    logic [15:0] ext_data_out, ext_data_in;
    logic as_n, rd_n, high_write_strobe_n, low_write_strobe_n, wait_n;
    logic [2:0] prv = 3'h7;
    int fails = 0, cmp_count = 0, cyc = 0, lat, np, gap, n_rd, n_hw, n_lw, n_as;
    logic [31:0] wcfg [6] = '{32'h07, 32'h03, 32'h0d, 32'h0d, 32'h16, 32'h16};
    logic [3:0] hold [6] = '{4'hf, 4'hf, 4'h4, 4'h0, 4'hf, 4'h0};
    int wlat [6] = '{7, 3, 8, 5, 6, 4};

    ebc_ctrl i_ebc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .req_valid, .req_ready, .req_write, .req_fetch, .req_size, .req_area, .req_addr,
        .req_wdata, .req_words, .rsp_valid, .rsp_last, .rsp_rdata, .ext_addr, .ext_data_out,
        .ext_data_oe_n, .ext_data_in, .as_n, .rd_n, .high_write_strobe_n, .low_write_strobe_n, .wait_n);
    ebc_mem_model i_ebc_mem_model (.pclk, .ext_addr, .ext_data_out, .rd_n, .high_write_strobe_n,
        .low_write_strobe_n, .wait_hold, .ext_data_in, .wait_n);

    initial forever #12.5 pclk = ~pclk;

    function automatic logic [15:0] mval(input logic [7:0] i);
        return {i ^ 8'ha5, i};
    endfunction

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Strobe falls, address strobe low cycles and driven lanes, counted per access
    always @(posedge pclk) begin
        cyc++;
        if (prv[2] && !rd_n) n_rd++;
        if (prv[1] && !high_write_strobe_n) n_hw++;
        if (prv[0] && !low_write_strobe_n) n_lw++;
        if (!as_n) n_as++;
        if (!(high_write_strobe_n && low_write_strobe_n)) oe_seen |= ~ext_data_oe_n;
        prv <= {rd_n, high_write_strobe_n, low_write_strobe_n};
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask

    // Latency counts cycles from the take edge to the final answer
    task automatic access(input logic w, f, input logic [1:0] sz, ar, input logic [23:0] a,
                          input logic [31:0] wd, input logic [3:0] nw);
        int t0;
        {n_rd, n_hw, n_lw, n_as, np, lat, gap, t0} = '0;
        oe_seen = 2'h0;
        {req_valid, req_write, req_fetch, req_size, req_area, req_addr, req_wdata, req_words} <=
            {1'b1, w, f, sz, ar, a, wd, nw};
        @(posedge pclk);
        req_valid <= 1'b0;
        for (int k = 1; k < 400 && lat == 0; k++) begin
            @(posedge pclk);
            if (k == 1) chk(req_ready, 32'h0);
            if (rsp_valid === 1'b1) begin
                np++;
                if (np == 1) t0 = k;
                q = rsp_rdata;
                if (rsp_last === 1'b1) begin
                    lat = k;
                    gap = k - t0;
                end
            end
        end
        @(posedge pclk);
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 8'h00, 0);
        chk(q, 32'h7);
        apb(0, 8'h04, 0);
        chk(q, 32'hf);
        apb(0, 8'h10, 0);
        chk({31'h0, e}, 32'h1);
        // Program, 2-state, pin and auto waits against a slow device
        for (int i = 0; i < 6; i++) begin
            apb(1, 8'h00, wcfg[i]);
            wait_hold <= hold[i];
            access(0, 0, 1, 0, 24'h10, 0, 0);
            chk(lat, wlat[i]);
            chk(n_as + 1, wlat[i]);
            chk(q, {16'h0, mval(8'h08)});
        end
        apb(1, 8'h00, 32'h0);
        access(1, 0, 0, 0, 24'h21, 32'h3c, 0);
        chk(n_hw * 16 + n_lw + oe_seen * 256, 32'h101);
        access(1, 0, 0, 0, 24'h20, 32'hc3, 0);
        chk(n_hw * 16 + n_lw + oe_seen * 256, 32'h210);
        access(0, 0, 1, 0, 24'h20, 0, 0);
        chk(q + n_rd * 32'h10000, 32'h1c33c);
        apb(1, 8'h08, 32'h10);
        access(0, 0, 2, 0, 24'h30, 0, 0);
        chk(q, 32'hbdbdbcbc);
        chk(n_rd, 4);
        access(1, 0, 1, 0, 24'h40, 32'h1234, 0);
        chk(n_hw * 16 + n_lw + oe_seen * 256, 32'h220);
        // Multiplexed bus: address wait, capped auto wait, pin wait
        apb(1, 8'h08, 32'h08);
        apb(1, 8'h04, 32'h12);
        apb(1, 8'h00, 32'h04);
        access(0, 0, 1, 1, 24'h10, 0, 0);
        chk(lat, 9);
        chk(n_as, 3);
        apb(1, 8'h00, 32'h15);
        wait_hold <= 4'hf;
        access(0, 0, 1, 0, 24'h10, 0, 0);
        chk(lat, 7);
        apb(1, 8'h00, 32'h0d);
        wait_hold <= 4'h0;
        access(0, 0, 1, 0, 24'h10, 0, 0);
        chk(lat, 7);
        access(1, 0, 0, 0, 24'h21, 32'h5a, 0);
        chk(n_hw * 16 + n_lw, 1);
        access(1, 0, 0, 0, 24'h20, 32'ha5, 0);
        chk(n_hw * 16 + n_lw, 32'h10);
        // Burst fetches: word limit and cycle length
        apb(1, 8'h08, 32'h01);
        access(0, 1, 1, 0, 24'h50, 0, 8);
        chk(np * 256 + gap, 32'h403);
        chk({16'h0, q[15:0]}, {16'h0, mval(8'h2b)});
        apb(1, 8'h08, 32'h07);
        access(0, 1, 1, 0, 24'h50, 0, 8);
        chk(np * 256 + gap, 32'h80e);
        access(0, 0, 1, 0, 24'h50, 0, 8);
        chk(np, 1);
        report_and_stop();
    end
endmodule
